// ===== design/dual_compare_pulse_output.sv
// Dual compare pulse output channel: single and continuous pulse modes
`timescale 1ns/1ps

// What this block does
// - Modes 100 and 101 select dual compare
// - Primary match produces the rising edge
// - Secondary match then produces the falling edge
// - Single pulse starts low until primary match
// - Output rises one clock after primary match
// - Single pulse stays low after falling edge
// - Time base wraps to zero after period
// - Secondary beyond period: no falling edge
// - Falling edge sets the channel interrupt flag
// - Flag and enable raise interrupt request
// - Single pulse produces no further pulses
// - Rewriting mode 100 arms a new pulse
// - Continuous mode repeats pulse every period
// - Primary beyond period keeps output low
// - Secondary not above primary falls after wrap
// - Reset forces the output logic low
module dual_compare_pulse_output
	import dual_compare_pkg::*;
(
	// Clock and reset
	input  wire logic                                     ref_clk,
	input  wire logic                                     reset_n,
	// Channel control
	input  wire logic [dual_compare_pkg::MODE_WIDTH-1:0]  compareModeField,
	input  wire logic                                     modeWriteStrobe,
	input  wire logic                                     channelEnable,
	input  wire logic                                     wideMode,
	input  wire logic                                     timeBaseSelect,
	// Compare values
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] primaryCompareValue,
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] secondaryCompareValue,
	// Time bases from the two timers
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] timeBaseCountA,
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] timeBasePeriodA,
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] timeBaseCountB,
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] timeBasePeriodB,
	input  wire logic                                     timeBaseRunning,
	// Interrupt handshake
	input  wire logic                                     channelIrqEnable,
	input  wire logic                                     channelIrqFlagClear,
	// Results
	output logic                                          compareOutputPin,
	output logic                                          channelIrqFlag,
	output logic                                          channelIrqRequest,
	output logic                                          pulseArmed
);
	// All channel state in one record
	typedef struct packed {
		pulse_state_t phase;
		logic         pin;
		logic         flag;
	} chan_state_t;

	chan_state_t                    state_reg;
	chan_state_t                    state_next;
	logic [COUNT_WIDTH-1:0]         selCount;
	logic [COUNT_WIDTH-1:0]         selPeriod;
	logic                           riseHit;
	logic                           fallHit;
	logic                           riseReach;
	logic                           fallReach;
	logic                           dualMode;
	logic                           armWrite;

	// Wide mode always pairs the timers, so it uses the first time base
	always_comb begin
		if (timeBaseSelect && !wideMode) begin
			selCount  = timeBaseCountB;
			selPeriod = timeBasePeriodB;
		end else begin
			selCount  = timeBaseCountA;
			selPeriod = timeBasePeriodA;
		end
	end

	// Primary compare: rising edge
	compare_match riseCmp (
		.count     (selCount),
		.value     (primaryCompareValue),
		.period    (selPeriod),
		.wide      (wideMode),
		.hit       (riseHit),
		.reachable (riseReach)
	);

	// Secondary compare: falling edge
	compare_match fallCmp (
		.count     (selCount),
		.value     (secondaryCompareValue),
		.period    (selPeriod),
		.wide      (wideMode),
		.hit       (fallHit),
		.reachable (fallReach)
	);

	// Mode decode and re-arm detection
	always_comb begin
		dualMode = channelEnable && ((compareModeField == MODE_SINGLE_PULSE) ||
			(compareModeField == MODE_CONT_PULSE));
		armWrite = modeWriteStrobe && dualMode;
	end

	// Next state; pin is registered so it moves one clock after the match
	always_comb begin
		state_next = state_reg;
		if (!dualMode) begin
			// Mode change or disable drops the pin and rearms for later
			state_next.phase = WAIT_RISE;
			state_next.pin   = PIN_RESET;
		end else if (armWrite) begin
			state_next.phase = WAIT_RISE;
			state_next.pin   = PIN_RESET;
		end else if (timeBaseRunning) begin
			unique case (state_reg.phase)
				WAIT_RISE: begin
					// Out-of-range primary never matches; pin stays low
					if (riseHit && riseReach) begin
						state_next.pin   = 1'b1;
						state_next.phase = WAIT_FALL;
					end
				end
				WAIT_FALL: begin
					// Unreachable secondary holds the pin high
					// Equal or lower secondary waits for the wrapped count
					if (fallHit && fallReach) begin
						state_next.pin   = 1'b0;
						state_next.flag  = 1'b1;
						state_next.phase = (compareModeField == MODE_CONT_PULSE) ?
							WAIT_RISE : DONE;
					end
				end
				DONE: begin
					state_next.pin = 1'b0;
				end
			endcase
		end
		// Setting a low flag beats a clear in the same cycle
		if (channelIrqFlagClear && !(state_next.flag && !state_reg.flag))
			state_next.flag = 1'b0;
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg.phase <= WAIT_RISE;
			state_reg.pin   <= PIN_RESET;
			state_reg.flag  <= FLAG_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs
	always_comb begin
		compareOutputPin  = state_reg.pin;
		channelIrqFlag    = state_reg.flag;
		channelIrqRequest = state_reg.flag && channelIrqEnable;
		pulseArmed        = dualMode && (state_reg.phase != DONE);
	end
endmodule

// ===== design/dual_compare_pkg.sv
// Shared constants and types for the dual compare pulse output channel
package dual_compare_pkg;
	// Mode field encodings
	localparam logic [2:0] MODE_DISABLED     = 3'h0;
	localparam logic [2:0] MODE_SINGLE_PULSE = 3'h4;
	localparam logic [2:0] MODE_CONT_PULSE   = 3'h5;
	localparam int         MODE_WIDTH        = 3;
	// Control field positions
	localparam int         TIME_BASE_SEL_BIT = 3;
	localparam int         TIMER_ON_BIT      = 15;
	// Data widths
	localparam int         COUNT_WIDTH       = 32;
	localparam int         HALF_WIDTH        = 16;
	// Reset values
	localparam logic       PIN_RESET         = 1'b0;
	localparam logic       FLAG_RESET        = 1'b0;
	// Output edge latency after a match, in peripheral clock cycles
	localparam int         EDGE_DELAY_CYCLES = 1;
	// Pulse sequencing states
	typedef enum logic [1:0] {
		WAIT_RISE,
		WAIT_FALL,
		DONE
	} pulse_state_t;
endpackage

// ===== design/compare_match.sv
// Width-selectable equality compare of a value against the time base
`timescale 1ns/1ps
module compare_match
	import dual_compare_pkg::*;
(
	// Operands
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] count,
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] value,
	input  wire logic [dual_compare_pkg::COUNT_WIDTH-1:0] period,
	input  wire logic                                     wide,
	// Results
	output logic                                          hit,
	output logic                                          reachable
);
	// Narrow mode ignores the upper half of all operands
	function automatic logic [COUNT_WIDTH-1:0] trim(input logic [COUNT_WIDTH-1:0] v,
			input logic w);
		trim = w ? v : {{HALF_WIDTH{1'b0}}, v[HALF_WIDTH-1:0]};
	endfunction

	// Match and period-range check at the selected width
	always_comb begin
		hit       = trim(count, wide) == trim(value, wide);
		reachable = trim(value, wide) <= trim(period, wide);
	end
endmodule

// ===== test/time_base_model.sv
// Time base partner model: counts to its period, then wraps to zero
`timescale 1ns/1ps
module time_base_model (
	// Clock, reset and control
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        run,
	input  wire logic [31:0] period,
	// Count
	output logic      [31:0] count
);
	// Stopping also clears, so every pulse starts from a known zero
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n || !run) count <= 32'h0;
		else count <= (count >= period) ? 32'h0 : count + 32'h1;
endmodule

// ===== test/dual_compare_asserts.sv
// Checker for the dual compare pulse output channel
`timescale 1ns/1ps
module dual_compare_asserts
	import dual_compare_pkg::*;
(
	// Clock, reset and control
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic [2:0]  compareModeField,
	input wire logic        modeWriteStrobe,
	input wire logic        channelEnable,
	input wire logic        wideMode,
	input wire logic        timeBaseSelect,
	input wire logic        timeBaseRunning,
	input wire logic        channelIrqEnable,
	// Values and time bases
	input wire logic [31:0] primaryCompareValue,
	input wire logic [31:0] secondaryCompareValue,
	input wire logic [31:0] timeBaseCountA,
	input wire logic [31:0] timeBaseCountB,
	// Results
	input wire logic        compareOutputPin,
	input wire logic        channelIrqFlag,
	input wire logic        channelIrqRequest
);
	logic [31:0] cnt;
	logic [31:0] msk;
	logic        dual;
	logic        priHit;
	logic        secHit;
	// Selected count, masked to the compare width in use
	assign cnt = (!wideMode && timeBaseSelect) ? timeBaseCountB : timeBaseCountA;
	assign msk = wideMode ? 32'hffffffff : 32'h0000ffff;
	assign dual = channelEnable && compareModeField[2:1] == 2'h2;
	assign priHit = ((cnt ^ primaryCompareValue) & msk) == 32'h0;
	assign secHit = ((cnt ^ secondaryCompareValue) & msk) == 32'h0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_rise; $rose(compareOutputPin); endsequence
	sequence s_fall;
		$fell(compareOutputPin) && $past(secHit && !modeWriteStrobe)
			&& compareModeField == MODE_SINGLE_PULSE;
	endsequence
	property p_rise; s_rise |-> $past(priHit && timeBaseRunning && dual); endproperty
	property p_fall;
		$fell(compareOutputPin) && $past(dual && !modeWriteStrobe) |-> $past(secHit);
	endproperty
	property p_once; s_fall ##1 (!modeWriteStrobe)[*8] |-> !compareOutputPin; endproperty
	property p_flag; $rose(channelIrqFlag) |-> $fell(compareOutputPin); endproperty
	property p_req; channelIrqRequest == (channelIrqFlag && channelIrqEnable); endproperty
	property p_idle; !dual |=> !compareOutputPin; endproperty
	property p_arm; modeWriteStrobe && dual |=> !compareOutputPin; endproperty
	property p_hold;
		!timeBaseRunning && !modeWriteStrobe && dual |=> $stable(compareOutputPin);
	endproperty
	property p_rst; disable iff (1'b0) !reset_n |-> !compareOutputPin && !channelIrqFlag;
	endproperty
	a_rise: assert property (p_rise) else $error("rise without primary match");
	a_fall: assert property (p_fall) else $error("fall without secondary match");
	a_once: assert property (p_once) else $error("extra single pulse");
	a_flag: assert property (p_flag) else $error("flag set off the fall");
	a_req: assert property (p_req) else $error("request not flag and enable");
	a_idle: assert property (p_idle) else $error("pin high outside dual mode");
	a_arm: assert property (p_arm) else $error("pin high after mode write");
	a_hold: assert property (p_hold) else $error("pin moved while stopped");
	a_rst: assert property (p_rst) else $error("outputs high in reset");
endmodule
bind dual_compare_pulse_output dual_compare_asserts dual_compare_asserts_i (.*);

// ===== test/dual_compare_pulse_output_tb.sv
// Testbench for the dual compare pulse output channel
`timescale 1ns/1ps
module dual_compare_pulse_output_tb;
	logic ref_clk = 0, strb = 0, run = 0, wide = 0, ie = 0, clr = 0, en = 1;
	logic reset_n;
	logic pin, flg, req, arm;
	logic [2:0] md = 0;
	logic [31:0] p = 0, s = 0, per = 0, cnt;
	int failures = 0, checked = 0;
	time_base_model time_base_model_i (.ref_clk, .reset_n, .run, .period(per), .count(cnt));
	dual_compare_pulse_output dual_compare_pulse_output_i (.ref_clk, .reset_n,
		.compareModeField(md), .modeWriteStrobe(strb), .channelEnable(en), .wideMode(wide),
		.timeBaseSelect(1'b0), .primaryCompareValue(p), .secondaryCompareValue(s),
		.timeBaseCountA(cnt), .timeBasePeriodA(per), .timeBaseCountB(cnt),
		.timeBasePeriodB(per), .timeBaseRunning(run), .channelIrqEnable(ie),
		.channelIrqFlagClear(clr), .compareOutputPin(pin), .channelIrqFlag(flg),
		.channelIrqRequest(req), .pulseArmed(arm));
	initial forever #4 ref_clk = ~ref_clk;
	task automatic cmpN(input string n, input int e, g);
		checked++;
		if (e != g) begin
			failures++;
			$display("mismatch %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic cmpB(input string n, input logic e, g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	// Arm with the time base held at zero, then time the edges over 30 cycles
	task automatic go(input logic [2:0] m, input logic [31:0] a, b, c, input logic w, e,
		input int er, ef, ek, input logic efl);
		int r = 0, f = 0, k = 0;
		logic lv = 0;
		@(negedge ref_clk);
		{run, md, p, s, per, wide, ie, strb, clr} = {1'b0, m, a, b, c, w, e, 2'h3};
		@(negedge ref_clk);
		{strb, clr, run} = 3'h1;
		for (int n = 1; n <= 30; n++) begin
			@(negedge ref_clk);
			if (pin && r == 0) r = n;
			if (!pin && r != 0 && f == 0) f = n;
			if (pin && !lv) k++;
			lv = pin;
		end
		cmpN("rise", er, r);
		cmpN("fall", ef, f);
		cmpN("rises", ek, k);
		cmpB("flag", efl, flg);
		cmpB("request", efl & e, req);
		cmpB("armed", !(m == 3'h4 && ef != 0), arm);
	endtask
	task automatic sSingle;
		go(3'h4, 32'h3, 32'h7, 32'ha, 1'b0, 1'b1, 4, 8, 1, 1'b1);
	endtask
	task automatic sRearm;
		go(3'h4, 32'h0, 32'h1, 32'h4, 1'b0, 1'b0, 1, 2, 1, 1'b1);
	endtask
	task automatic sCont;
		go(3'h5, 32'h2, 32'h5, 32'h8, 1'b0, 1'b1, 3, 6, 4, 1'b1);
	endtask
	// Pulse left high, then the channel is switched off: pin must drop
	task automatic sNoFall;
		go(3'h4, 32'h2, 32'hc, 32'h8, 1'b0, 1'b1, 3, 0, 1, 1'b0);
		en = 1'b0;
		@(negedge ref_clk);
		cmpB("disabled pin", 1'b0, pin);
		en = 1'b1;
	endtask
	task automatic sNoRise;
		go(3'h4, 32'h9, 32'ha, 32'h8, 1'b0, 1'b1, 0, 0, 0, 1'b0);
	endtask
	task automatic sWrap;
		go(3'h4, 32'h5, 32'h2, 32'h8, 1'b0, 1'b1, 6, 12, 1, 1'b1);
	endtask
	task automatic sWidth;
		go(3'h4, 32'h00ab0003, 32'h00ab0005, 32'ha, 1'b0, 1'b1, 4, 6, 1, 1'b1);
		go(3'h4, 32'h00ab0003, 32'h00ab0005, 32'ha, 1'b1, 1'b1, 0, 0, 0, 1'b0);
	endtask
	task automatic summarize;
		if (failures == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Main sequence after twelve cycles of reset
	initial begin
		reset_n = 0;
		repeat (12) @(negedge ref_clk);
		reset_n = 1;
		sSingle();
		sRearm();
		sCont();
		sNoFall();
		sNoRise();
		sWrap();
		sWidth();
		summarize();
	end
	// Watchdog: the run needs about 2.2 us
	initial begin
		#20us;
		failures++;
		summarize();
	end
endmodule
